// [rtl/rcc_pkg.sv]
// constants, types and decode helpers for the radio core control/status bank
// assumes a 32-bit AXI4-Lite register bus and byte addresses as printed
package rcc_pkg;
    localparam logic [31:0] ADDR_CTRL2 = 32'h40000200;
    localparam logic [31:0] ADDR_XBASE = 32'h40000208;
    localparam logic [31:0] ADDR_ISTAT = 32'h40000280;
    localparam logic [31:0] ADDR_IMASK = 32'h40000284;

    // control two field positions, plus the base register field offset
    localparam int RSSI_SEL  = 21;
    localparam int WAKE_STAT = 20;
    localparam int KEEP_LSB  = 18;
    localparam int PTI_SEL   = 17;
    localparam int MHZ_LSB   = 9;
    localparam int PWRDN     = 8;
    localparam int LP_SEEN   = 7;
    localparam int CLK_STAT  = 6;
    localparam int SPARE_LSB = 4;
    localparam int DIAG_OVR  = 3;
    localparam int ERR_MASK  = 2;
    localparam int ERR_ACK   = 1;
    localparam int ERR_STAT  = 0;
    localparam int XBASE_LSB = 10;

    localparam int MHZ_W   = 6;
    localparam int XBASE_W = 7;
    localparam int KEEP_W  = 2;
    localparam int SPARE_W = 2;
    localparam int EV_W    = 4;
    localparam int RSSI_W  = 8;
    localparam int PTI_W   = 4;
    localparam int DIAG_W  = 8;
    localparam int PAGE_W  = 4;

    // event status / mask bits
    localparam int EV_LP    = 0;
    localparam int EV_PWRDN = 1;
    localparam int EV_WAKE  = 2;
    localparam int EV_XERR  = 3;

    localparam logic               ERR_MASK_RST = 1'b1;
    localparam logic [XBASE_W-1:0] XBASE_RST    = 7'h00;
    localparam logic [EV_W-1:0]    IMASK_RST    = 4'h0;

    // slow clock edges from deep sleep request to power-down permission
    localparam logic [1:0] PD_LP_EDGES = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        RCC_SEL_NONE,
        RCC_SEL_CTRL2,
        RCC_SEL_XBASE,
        RCC_SEL_ISTAT,
        RCC_SEL_IMASK
    } rcc_sel_e;

    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_PEND,
        WAKE_UP,
        WAKE_EDGE1
    } rcc_wake_e;

    function automatic rcc_sel_e rcc_decode(input logic [31:0] a);
        if (a == ADDR_CTRL2) begin
            return RCC_SEL_CTRL2;
        end else if (a == ADDR_XBASE) begin
            return RCC_SEL_XBASE;
        end else if (a == ADDR_ISTAT) begin
            return RCC_SEL_ISTAT;
        end else if (a == ADDR_IMASK) begin
            return RCC_SEL_IMASK;
        end else begin
            return RCC_SEL_NONE;
        end
    endfunction

    function automatic logic [31:0] rcc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return (old_v & ~m) | (new_v & m);
    endfunction
endpackage

// [rtl/rcc_lp_edge.sv]
// rising edge detector for the low-power clock, sampled on the master clock
// assumes the slow clock is at most half the master clock rate
module rcc_lp_edge (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic lp_clock,
    input  wire logic hold,
    output logic      edge_pulse
);
    typedef struct packed {
        logic prev;
        logic pulse;
    } rcc_edge_s;

    rcc_edge_s q;
    rcc_edge_s d;

    always_comb begin
        d = q;
        d.prev = lp_clock;
        // no edge is reported while the slow timer sits in reset
        d.pulse = lp_clock && !q.prev && !hold;
    end

    // prev resets high so a slow clock already high gives no false edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{prev: 1'b1, pulse: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign edge_pulse = q.pulse;
endmodule

// [rtl/rcc_ctrl_status.sv]
// radio core control/status bank with AXI4-Lite slave and event interrupt
// assumes all inputs synchronous to clock; slow clock sampled as data
//
// The AXI4-Lite interface to the registers is this design's own decision.
module rcc_ctrl_status (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        lp_clock,
    input  wire logic        slow_timer_reset,
    input  wire logic [7:0]  strength_peak,
    input  wire logic [7:0]  strength_avg,
    output logic [7:0]       signal_strength_value,
    input  wire logic [3:0]  pti_ctrl_struct,
    input  wire logic [3:0]  pti_core_dyn,
    output logic [3:0]       pti_to_coexistence_block,
    output logic [5:0]       master_clock_mhz,
    input  wire logic        core_on_master_clock,
    input  wire logic        deep_sleep_request,
    input  wire logic        sleep_exit_interrupt,
    input  wire logic        wakeup_request,
    input  wire logic        radio_powered_up,
    output logic             lowpower_wakeup_interrupt,
    output logic             powerdown_permitted,
    input  wire logic [7:0]  diag_core_in,
    input  wire logic [7:0]  diag_override_value,
    output logic [7:0]       core_diagnostic_bus,
    input  wire logic        xmem_access,
    input  wire logic [3:0]  xmem_page,
    input  wire logic [3:0]  xmem_page_mapping,
    output logic             xmem_error_irq,
    output logic [31:0]      xmem_base_address,
    output logic             irq
);
    typedef struct packed {
        logic                             aw_held;
        logic [31:0]                      awaddr;
        logic                             w_held;
        logic [31:0]                      wdata;
        logic [3:0]                       wstrb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [1:0]                       rresp;
        logic [31:0]                      rdata;
        logic                             rssi_sel;
        logic [rcc_pkg::KEEP_W-1:0]       keep;
        logic                             pti_sel;
        logic [rcc_pkg::MHZ_W-1:0]        mhz;
        logic [rcc_pkg::SPARE_W-1:0]      spare;
        logic                             diag_ovr;
        logic                             err_mask;
        logic                             err_stat;
        rcc_pkg::rcc_wake_e               wake;
        logic                             pd;
        logic [1:0]                       pd_cnt;
        logic                             lp_seen;
        logic [rcc_pkg::XBASE_W-1:0]      xbase;
        logic [rcc_pkg::EV_W-1:0]         ev_stat;
        logic [rcc_pkg::EV_W-1:0]         ev_mask;
        logic [rcc_pkg::RSSI_W-1:0]       rssi_out;
        logic [rcc_pkg::PTI_W-1:0]        pti_out;
        logic [rcc_pkg::DIAG_W-1:0]       diag_out;
    } rcc_state_s;

    localparam rcc_state_s RST = '{
        err_mask: rcc_pkg::ERR_MASK_RST,
        xbase:    rcc_pkg::XBASE_RST,
        ev_mask:  rcc_pkg::IMASK_RST,
        wake:     rcc_pkg::WAKE_IDLE,
        default:  '0
    };

    rcc_state_s          q;
    rcc_state_s          d;
    rcc_pkg::rcc_sel_e   wsel;
    rcc_pkg::rcc_sel_e   rsel;
    logic                wr_fire;
    logic                wr_ctrl2;
    logic                ack_wr;
    logic                lp_clr;
    logic                err_ev;
    logic                lp_edge;
    logic [31:0]         c2_img;
    logic [31:0]         xb_img;
    logic [31:0]         st_img;
    logic [31:0]         mk_img;
    logic [31:0]         c2_new;
    logic [31:0]         xb_new;
    logic [31:0]         mk_new;
    logic [rcc_pkg::EV_W-1:0] ev;

    rcc_lp_edge u_lp_edge (
        .clock      (clock),
        .rst_b      (rst_b),
        .lp_clock   (lp_clock),
        .hold       (slow_timer_reset),
        .edge_pulse (lp_edge)
    );

    assign wsel     = rcc_pkg::rcc_decode(q.awaddr);
    assign rsel     = rcc_pkg::rcc_decode(s_axi_araddr);
    assign wr_fire  = q.aw_held && q.w_held && !q.bvalid;
    assign wr_ctrl2 = wr_fire && (wsel == rcc_pkg::RCC_SEL_CTRL2);
    assign ack_wr   = wr_ctrl2 && c2_new[rcc_pkg::ERR_ACK];
    // a byte strobe covering bit 7 with a zero there is the only clear
    assign lp_clr   = wr_ctrl2 && q.wstrb[0] && !q.wdata[rcc_pkg::LP_SEEN];
    // page numbers at or past the mapped count are outside the mapping
    assign err_ev   = xmem_access && (xmem_page >= xmem_page_mapping);
    assign c2_new   = rcc_pkg::rcc_merge(c2_img, q.wdata, q.wstrb);
    assign xb_new   = rcc_pkg::rcc_merge(xb_img, q.wdata, q.wstrb);
    assign mk_new   = rcc_pkg::rcc_merge(mk_img, q.wdata, q.wstrb);

    // read images; unlisted bits stay zero
    always_comb begin
        c2_img = '0;
        c2_img[rcc_pkg::RSSI_SEL] = q.rssi_sel;
        c2_img[rcc_pkg::WAKE_STAT] = (q.wake != rcc_pkg::WAKE_IDLE);
        c2_img[rcc_pkg::KEEP_LSB +: rcc_pkg::KEEP_W] = q.keep;
        c2_img[rcc_pkg::PTI_SEL] = q.pti_sel;
        c2_img[rcc_pkg::MHZ_LSB +: rcc_pkg::MHZ_W] = q.mhz;
        c2_img[rcc_pkg::PWRDN] = q.pd;
        c2_img[rcc_pkg::LP_SEEN] = q.lp_seen;
        c2_img[rcc_pkg::CLK_STAT] = core_on_master_clock;
        c2_img[rcc_pkg::SPARE_LSB +: rcc_pkg::SPARE_W] = q.spare;
        c2_img[rcc_pkg::DIAG_OVR] = q.diag_ovr;
        c2_img[rcc_pkg::ERR_MASK] = q.err_mask;
        c2_img[rcc_pkg::ERR_STAT] = q.err_stat;
        xb_img = '0;
        xb_img[rcc_pkg::XBASE_LSB +: rcc_pkg::XBASE_W] = q.xbase;
        st_img = '0;
        st_img[rcc_pkg::EV_W-1:0] = q.ev_stat;
        mk_img = '0;
        mk_img[rcc_pkg::EV_W-1:0] = q.ev_mask;
    end

    always_comb begin
        d = q;
        ev = '0;
        // bus: address and data taken independently, then one write
        if (s_axi_awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_held) begin
            d.w_held = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            if (wsel == rcc_pkg::RCC_SEL_NONE) begin
                d.bresp = rcc_pkg::RESP_DECERR;
            end else begin
                d.bresp = rcc_pkg::RESP_OKAY;
            end
        end
        // only named fields are stored; reserved write bits are dropped
        if (wr_ctrl2) begin
            d.rssi_sel = c2_new[rcc_pkg::RSSI_SEL];
            d.keep = c2_new[rcc_pkg::KEEP_LSB +: rcc_pkg::KEEP_W];
            d.pti_sel = c2_new[rcc_pkg::PTI_SEL];
            d.mhz = c2_new[rcc_pkg::MHZ_LSB +: rcc_pkg::MHZ_W];
            d.spare = c2_new[rcc_pkg::SPARE_LSB +: rcc_pkg::SPARE_W];
            d.diag_ovr = c2_new[rcc_pkg::DIAG_OVR];
            d.err_mask = c2_new[rcc_pkg::ERR_MASK];
        end
        if (wr_fire && (wsel == rcc_pkg::RCC_SEL_XBASE)) begin
            d.xbase = xb_new[rcc_pkg::XBASE_LSB +: rcc_pkg::XBASE_W];
        end
        if (wr_fire && (wsel == rcc_pkg::RCC_SEL_IMASK)) begin
            d.ev_mask = mk_new[rcc_pkg::EV_W-1:0];
        end

        // error status: ack clears, a same-cycle error still sets
        if (ack_wr) begin
            d.err_stat = 1'b0;
        end
        if (err_ev) begin
            d.err_stat = 1'b1;
        end

        // slow clock monitor; edge beats a same-cycle software clear
        if (lp_clr) begin
            d.lp_seen = 1'b0;
        end
        if (lp_edge) begin
            d.lp_seen = 1'b1;
        end

        // power-down permission counts slow edges while sleep is requested
        if (!deep_sleep_request) begin
            d.pd_cnt = '0;
        end else if (lp_edge && !q.pd) begin
            if (q.pd_cnt == rcc_pkg::PD_LP_EDGES - 2'h1) begin
                d.pd = 1'b1;
            end else begin
                d.pd_cnt = q.pd_cnt + 2'h1;
            end
        end
        if (sleep_exit_interrupt) begin
            d.pd = 1'b0;
            d.pd_cnt = '0;
        end

        // wakeup: two slow edges after power-up guarantee one full period
        case (q.wake)
            rcc_pkg::WAKE_IDLE: begin
                if (wakeup_request) begin
                    d.wake = rcc_pkg::WAKE_PEND;
                end
            end
            rcc_pkg::WAKE_PEND: begin
                if (radio_powered_up) begin
                    d.wake = rcc_pkg::WAKE_UP;
                end
            end
            rcc_pkg::WAKE_UP: begin
                if (lp_edge) begin
                    d.wake = rcc_pkg::WAKE_EDGE1;
                end
            end
            default: begin
                if (lp_edge) begin
                    ev[rcc_pkg::EV_WAKE] = 1'b1;
                    if (wakeup_request) begin
                        d.wake = rcc_pkg::WAKE_PEND;
                    end else begin
                        d.wake = rcc_pkg::WAKE_IDLE;
                    end
                end
            end
        endcase

        // sticky events, write one to clear, new event wins
        ev[rcc_pkg::EV_LP] = lp_edge;
        ev[rcc_pkg::EV_PWRDN] = d.pd && !q.pd;
        ev[rcc_pkg::EV_XERR] = err_ev;
        if (wr_fire && (wsel == rcc_pkg::RCC_SEL_ISTAT)) begin
            d.ev_stat = q.ev_stat & ~(q.wdata[rcc_pkg::EV_W-1:0] & {4{q.wstrb[0]}});
        end
        d.ev_stat = d.ev_stat | ev;

        // steered outputs, one register stage
        d.rssi_out = q.rssi_sel ? strength_avg : strength_peak;
        d.pti_out = q.pti_sel ? pti_core_dyn : pti_ctrl_struct;
        d.diag_out = q.diag_ovr ? diag_override_value : diag_core_in;

        // read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = rcc_pkg::RESP_OKAY;
            if (rsel == rcc_pkg::RCC_SEL_CTRL2) begin
                d.rdata = c2_img;
            end else if (rsel == rcc_pkg::RCC_SEL_XBASE) begin
                d.rdata = xb_img;
            end else if (rsel == rcc_pkg::RCC_SEL_ISTAT) begin
                d.rdata = st_img;
            end else if (rsel == rcc_pkg::RCC_SEL_IMASK) begin
                d.rdata = mk_img;
            end else begin
                d.rdata = '0;
                d.rresp = rcc_pkg::RESP_DECERR;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_held;
    assign s_axi_wready = !q.w_held;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign signal_strength_value = q.rssi_out;
    assign pti_to_coexistence_block = q.pti_out;
    // frequency is passed on as written; software must not change it live
    assign master_clock_mhz = q.mhz;
    assign lowpower_wakeup_interrupt = (q.wake != rcc_pkg::WAKE_IDLE);
    assign powerdown_permitted = q.pd;
    assign core_diagnostic_bus = q.diag_out;
    assign xmem_error_irq = q.err_stat && q.err_mask;
    assign xmem_base_address = xb_img;
    assign irq = |(q.ev_stat & q.ev_mask);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_err_event;
        err_ev && q.err_mask && !wr_ctrl2;
    endsequence
    sequence s_wake_release;
        (q.wake == rcc_pkg::WAKE_EDGE1) && lp_edge && !wakeup_request;
    endsequence

    property p_rssi;
        1 |=> signal_strength_value == ($past(q.rssi_sel) ?
              $past(strength_avg) : $past(strength_peak));
    endproperty
    a_rssi: assert property (p_rssi) else $error("strength select wrong");
    property p_wake_ack;
        s_wake_release |=> !lowpower_wakeup_interrupt;
    endproperty
    a_wake_ack: assert property (p_wake_ack) else $error("wakeup not acked");
    property p_wake_hold;
        lowpower_wakeup_interrupt && !lp_edge |=> lowpower_wakeup_interrupt;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wakeup dropped early");
    property p_pti;
        !q.pti_sel ##1 !q.pti_sel |-> pti_to_coexistence_block == $past(pti_ctrl_struct);
    endproperty
    a_pti: assert property (p_pti) else $error("priority source wrong");
    property p_mhz;
        wr_ctrl2 && q.wstrb[1]
            |=> master_clock_mhz == $past(c2_new[rcc_pkg::MHZ_LSB +: rcc_pkg::MHZ_W]);
    endproperty
    a_mhz: assert property (p_mhz) else $error("frequency not stored");
    property p_pd_rise;
        $rose(powerdown_permitted) |-> $past(lp_edge) && $past(deep_sleep_request);
    endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("power-down set early");
    property p_pd_exit;
        sleep_exit_interrupt |=> !powerdown_permitted;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down not cleared");
    property p_lp_set;
        lp_edge |=> q.lp_seen;
    endproperty
    a_lp_set: assert property (p_lp_set) else $error("slow edge not flagged");
    property p_lp_reset;
        slow_timer_reset && $past(slow_timer_reset) && !q.lp_seen |=> !q.lp_seen;
    endproperty
    a_lp_reset: assert property (p_lp_reset) else $error("edge flagged in reset");
    property p_clk_stat;
        s_axi_arvalid && s_axi_arready && (rsel == rcc_pkg::RCC_SEL_CTRL2)
            |=> s_axi_rdata[rcc_pkg::CLK_STAT] == $past(core_on_master_clock);
    endproperty
    a_clk_stat: assert property (p_clk_stat) else $error("clock status wrong");
    property p_diag;
        q.diag_ovr |=> core_diagnostic_bus == $past(diag_override_value);
    endproperty
    a_diag: assert property (p_diag) else $error("diag override missing");
    property p_err_irq;
        s_err_event |=> xmem_error_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq missing");
    property p_ack;
        ack_wr && !err_ev |=> !q.err_stat;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear");
    property p_err_set;
        err_ev |=> q.err_stat;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error not recorded");
    property p_err_sticky;
        q.err_stat && !ack_wr |=> q.err_stat;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error lost");
    property p_xbase_rd;
        s_axi_arvalid && s_axi_arready && (rsel == rcc_pkg::RCC_SEL_XBASE)
            |=> (s_axi_rdata[9:0] == 10'h000) && (s_axi_rdata[31:17] == 15'h0000);
    endproperty
    a_xbase_rd: assert property (p_xbase_rd) else $error("base low bits set");
    property p_rsvd_rd;
        s_axi_arvalid && s_axi_arready && (rsel == rcc_pkg::RCC_SEL_CTRL2)
            |=> (s_axi_rdata[31:22] == 10'h000) && (s_axi_rdata[16:15] == 2'h0)
                && !s_axi_rdata[1];
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read 1");
endmodule

// [verif/rcc_tb.sv]
// self-checking bench for the radio core control/status bank
// assumes rcc_pkg and rcc_ctrl_status compiled first; bench is the bus master
module radio_core_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] C2 = rcc_pkg::ADDR_CTRL2;
    localparam logic [31:0] XB = rcc_pkg::ADDR_XBASE;
    localparam logic [31:0] IS = rcc_pkg::ADDR_ISTAT;
    localparam logic [31:0] IM = rcc_pkg::ADDR_IMASK;
    logic        clock = 0, rst_b = 0, o;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, xba, d;
    logic [3:0]  wstrb = 4'hF, ptc = 4'h5, ptd = 4'hA, pto, page = 0, map = 0;
    logic        awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, awr, wrd, arr;
    logic        lpc = 0, lpr = 0, cm = 0, dsr = 0, sei = 0, wkr = 0, rpu = 0, xa = 0;
    logic        lwi, pdp, xei, irq;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  spk = 8'h11, sav = 8'h22, ssv, dci = 8'h33, dov = 8'h44, diag;
    logic [5:0]  mhz;
    int          n_mismatch = 0, checked = 0;
    // ordinary rows: address, write data, read-back, response
    logic [31:0] ra [6] = '{C2, C2, XB, XB, 32'h40000204, C2};
    logic [31:0] rw [6] = '{32'hFFFFFFFF, 32'h1000, 32'hFFFFFFFF, 32'h12400, 32'h5, 32'h2004};
    logic [31:0] re [6] = '{32'h2E7E3C, 32'h1000, 32'h1FC00, 32'h12400, 32'h0, 32'h2004};
    logic [1:0]  rs [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};

    rcc_ctrl_status u_rcc_ctrl_status (
        .clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .lp_clock(lpc), .slow_timer_reset(lpr), .strength_peak(spk), .strength_avg(sav),
        .signal_strength_value(ssv), .pti_ctrl_struct(ptc), .pti_core_dyn(ptd),
        .pti_to_coexistence_block(pto), .master_clock_mhz(mhz),
        .core_on_master_clock(cm), .deep_sleep_request(dsr), .sleep_exit_interrupt(sei),
        .wakeup_request(wkr), .radio_powered_up(rpu), .lowpower_wakeup_interrupt(lwi),
        .powerdown_permitted(pdp), .diag_core_in(dci), .diag_override_value(dov),
        .core_diagnostic_bus(diag), .xmem_access(xa), .xmem_page(page),
        .xmem_page_mapping(map), .xmem_error_irq(xei), .xmem_base_address(xba), .irq(irq));

    always #12.5 clock = ~clock;

    task test_done;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clock);
    endtask
    // bounded waits only: a missing answer ends the run as a mismatch
    task wr(input logic [31:0] a, input logic [31:0] v);
        int n;
        @(posedge clock);
        awaddr <= a; wdata <= v; awv <= 1; wv <= 1; br <= 1; n = 0;
        do begin
            @(posedge clock); n++;
            if (awv && awr) awv <= 0;
            if (wv && wrd) wv <= 0;
        end while (bv !== 1'b1 && n < 30);
        if (bv !== 1'b1) begin n_mismatch++; test_done(); end
        r = bresp; br <= 0;
    endtask
    task rc(input logic [31:0] a, input logic [31:0] e);
        int n;
        @(posedge clock);
        araddr <= a; arv <= 1; rr <= 1; n = 0;
        do begin
            @(posedge clock); n++;
            if (arv && arr) arv <= 0;
        end while (rv !== 1'b1 && n < 30);
        if (rv !== 1'b1) begin n_mismatch++; test_done(); end
        d = rdata; r = rresp; rr <= 0;
        chk(d, e);
    endtask
    // slow clock kept at a fifth of the master rate (high 2, low 3 cycles), within the sampler's limit
    task lp(input int k);
        repeat (k) begin
            @(posedge clock); lpc <= 1; cyc(2);
            lpc <= 0; cyc(2);
        end
    endtask
    task pulse_x(input logic [3:0] p);
        @(posedge clock); page <= p; xa <= 1;
        @(posedge clock); xa <= 0; cyc(2);
    endtask

    initial begin
        cyc(2); rst_b <= 1;
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], rw[i]); chk(32'(r), 32'(rs[i]));
            rc(ra[i], re[i]); chk(32'(r), 32'(rs[i]));
            if (ra[i] == C2) chk(32'(mhz), 32'(re[i][14:9]));
            else if (ra[i] == XB) chk(xba, re[i]);
        end
        $display("rows done");
        for (int s = 0; s < 2; s++) begin
            o = (s == 0); wr(C2, o ? 32'h22200C : 32'h2004); cyc(2);
            chk(32'(ssv), 32'(o ? sav : spk));
            chk(32'(pto), 32'(o ? ptd : ptc));
            chk(32'(diag), 32'(o ? dov : dci));
        end
        cm <= 1; cyc(1); rc(C2, 32'h2044); cm <= 0;
        map <= 4; pulse_x(4'h3); chk(32'(xei), 0);
        pulse_x(4'h5); chk(32'(xei), 1);
        wr(C2, 32'h2004); rc(C2, 32'h2005);
        wr(C2, 32'h2000); cyc(1); chk(32'(xei), 0);
        wr(C2, 32'h2002); rc(C2, 32'h2000);
        $display("steer and error done");
        lpr <= 1; lp(3); lpr <= 0; rc(C2, 32'h2000);
        lp(1); rc(C2, 32'h2080);
        wr(C2, 32'h2000); rc(C2, 32'h2000);
        dsr <= 1; lp(1); cyc(2); chk(32'(pdp), 0);
        lp(1); cyc(2); chk(32'(pdp), 1); rc(C2, 32'h2180);
        @(posedge clock); sei <= 1; dsr <= 0;
        @(posedge clock); sei <= 0; cyc(2); chk(32'(pdp), 0);
        @(posedge clock); wkr <= 1;
        @(posedge clock); wkr <= 0; cyc(2); rc(C2, 32'h102080);
        rpu <= 1; lp(1); rc(C2, 32'h102080); chk(32'(lwi), 1);
        // a second slow edge ends the wakeup; the pending bit then reads back clear
        lp(1); cyc(2); chk(32'(lwi), 0); rc(C2, 32'h2080);
        rc(IS, 32'hF); chk(32'(irq), 0);
        wr(IM, 32'hF); cyc(1); chk(32'(irq), 1);
        wr(IS, 32'hF); rc(IS, 32'h0); chk(32'(irq), 0);
        $display("slow clock and events done");
        @(posedge clock); rst_b <= 0; cyc(2); rst_b <= 1;
        rc(C2, 32'h4); rc(XB, 32'h0); chk(32'(mhz), 0);
        $display("reset done");
        test_done();
    end
endmodule
